/* rtl/blank_mask_pkg.sv */
// Types shared by the blanking mask gate
package blank_mask_pkg;
    // One mask gating control word, bit 15 down to bit 0
    typedef struct packed {
        logic blank_polarity_select;
        logic unimpl;
        logic or_in_c_true_en;
        logic or_in_c_inv_en;
        logic or_in_b_true_en;
        logic or_in_b_inv_en;
        logic or_in_a_true_en;
        logic or_in_a_inv_en;
        logic conj_out_inv_to_or;
        logic conj_out_true_to_or;
        logic conj_in_c_true_en;
        logic conj_in_c_inv_en;
        logic conj_in_b_true_en;
        logic conj_in_b_inv_en;
        logic conj_in_a_true_en;
        logic conj_in_a_inv_en;
    } mask_ctrl_t;

    // The three shared masking inputs
    typedef struct packed {
        logic mask_input_c;
        logic mask_input_b;
        logic mask_input_a;
    } mask_in_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

/* rtl/blank_mask_regs.svh */
// Register offsets, field positions and reset values of the blanking mask gate
`ifndef BLANK_MASK_REGS_SVH
`define BLANK_MASK_REGS_SVH
`define BM_CTRL0_OFF     8'h00
`define BM_CTRL1_OFF     8'h04
`define BM_CTRL2_OFF     8'h08
`define BM_STATUS_OFF    8'h0C
`define BM_CTRL_RESET    16'h0000
`define BM_CTRL_WMASK    16'hBFFF
`define BM_POL_BIT       15
`define BM_UNIMP_BIT     14
`define BM_ST_BLANK_LSB  0
`define BM_ST_CMP_LSB    3
`define BM_ST_MASK_LSB   6
`endif

/* rtl/comparator_blanking_mask_gate.sv */
// Blanking mask gate for three comparators with an APB register port
`timescale 1ns/100ps
`include "blank_mask_regs.svh"

// What this block does
// - polarity bit picks low or high suppression
// - bit 13 puts mask input C on OR
// - bit 12 puts inverted C on OR
// - bit 11 puts mask input B on OR
// - bit 10 puts inverted B on OR
// - bit 9 puts mask input A on OR
// - bit 8 puts inverted A on OR
// - bits 7/6 route inverted/true AND output
// - upper byte layout, bit 14 unimplemented
module comparator_blanking_mask_gate (
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    input  wire logic                     i_clk_en,
    input  wire blank_mask_pkg::apb_req_t i_apb,
    output logic                          o_pready,
    output logic                          o_pslverr,
    output logic [31:0]                   o_prdata,
    input  wire blank_mask_pkg::mask_in_t i_mask,
    input  wire logic [2:0]               i_cmp_raw,
    output logic [2:0]                    o_cmp_event,
    output logic [2:0]                    o_blank
);
    import blank_mask_pkg::*;

    mask_ctrl_t  ctrl [3];
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync3;
    logic [5:0]  filt;
    mask_in_t    msk;
    logic [2:0]  cmp_f;
    logic [2:0]  blank;
    logic [2:0]  conj_out;
    logic        setup;
    logic        access;
    logic        mapped;
    logic [1:0]  ctrl_idx;
    logic [31:0] next_rdata;
    logic [15:0] status;

    // Pins from outside: three stages, a change counts when stages 2 and 3 agree
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
        end else if (i_clk_en) begin
            sync1 <= {i_cmp_raw, i_mask};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Filtered value holds through a disagreement, which rejects one-cycle glitches
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            filt <= 6'h00;
        end else if (i_clk_en && (sync2 == sync3)) begin
            filt <= sync3;
        end
    end

    assign msk   = filt[2:0];
    assign cmp_f = filt[5:3];

    // APB phases and decode
    assign setup    = i_apb.psel && !i_apb.penable;
    assign access   = i_apb.psel && i_apb.penable;
    assign ctrl_idx = i_apb.paddr[3:2];
    assign mapped   = (i_apb.paddr == `BM_CTRL0_OFF) || (i_apb.paddr == `BM_CTRL1_OFF)
                   || (i_apb.paddr == `BM_CTRL2_OFF) || (i_apb.paddr == `BM_STATUS_OFF);
    // Frozen block cannot complete a transfer, so ready follows the enable
    assign o_pready = i_clk_en;

    // Control word writes; unimplemented bit never stores
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int k = 0; k < 3; k++) begin
                ctrl[k] <= `BM_CTRL_RESET;
            end
        end else if (i_clk_en && access && i_apb.pwrite && mapped
                     && (i_apb.paddr != `BM_STATUS_OFF)) begin
            ctrl[ctrl_idx] <= i_apb.pwdata[15:0] & `BM_CTRL_WMASK;
        end
    end

    // Status word shows live blanking, comparator and mask levels
    assign status = {7'h00, msk, cmp_f, blank};

    // Read data captured in the setup cycle, held through the access phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_apb.paddr == `BM_STATUS_OFF) begin
            next_rdata = {16'h0000, status};
        end else if (mapped) begin
            next_rdata = {16'h0000, ctrl[ctrl_idx]};
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_clk_en && setup) begin
            o_prdata  <= i_apb.pwrite ? 32'h0000_0000 : next_rdata;
            o_pslverr <= !mapped;
        end
    end

    // One gate pair per comparator
    for (genvar k = 0; k < 3; k++) begin : g_cmp
        logic [5:0] conj_terms;
        logic [5:0] conj_sel;
        logic [7:0] or_terms;
        logic [7:0] or_sel;

        // AND inputs in order C, /C, B, /B, A, /A
        assign conj_terms = {msk.mask_input_c, !msk.mask_input_c, msk.mask_input_b,
                             !msk.mask_input_b, msk.mask_input_a, !msk.mask_input_a};
        assign conj_sel   = ctrl[k][5:0];
        // With no input picked the AND gate gives low, so its true route cannot blank forever
        assign conj_out[k] = (|conj_sel) && (&(conj_terms | ~conj_sel));

        // OR inputs in order C, /C, B, /B, A, /A, /AND, AND
        assign or_terms = {conj_terms, !conj_out[k], conj_out[k]};
        assign or_sel   = {ctrl[k][13:8], ctrl[k][7:6]};
        assign blank[k] = |(or_terms & or_sel);

        // Blanked output is held at the level that is not asserted
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                o_cmp_event[k] <= 1'b0;
                o_blank[k]     <= 1'b0;
            end else if (i_clk_en) begin
                o_blank[k] <= blank[k];
                if (blank[k]) begin
                    o_cmp_event[k] <= ctrl[k].blank_polarity_select;
                end else begin
                    o_cmp_event[k] <= cmp_f[k];
                end
            end
        end

        pol_low_a : assert property (@(posedge i_clock) disable iff (i_rst)
            i_clk_en && blank[k] && ctrl[k].blank_polarity_select
            |=> o_cmp_event[k] == 1'b1)
            else $error("low event not blanked");
        pol_high_a : assert property (@(posedge i_clock) disable iff (i_rst)
            i_clk_en && blank[k] && !ctrl[k].blank_polarity_select
            |=> o_cmp_event[k] == 1'b0)
            else $error("high event not blanked");
        c_true_or_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].or_in_c_true_en && msk.mask_input_c |-> blank[k])
            else $error("input C did not blank");
        c_inv_or_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].or_in_c_inv_en && !msk.mask_input_c |-> blank[k])
            else $error("inverted C did not blank");
        b_true_or_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].or_in_b_true_en && msk.mask_input_b |-> blank[k])
            else $error("input B did not blank");
        b_inv_or_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].or_in_b_inv_en && !msk.mask_input_b |-> blank[k])
            else $error("inverted B did not blank");
        a_true_or_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].or_in_a_true_en && msk.mask_input_a |-> blank[k])
            else $error("input A did not blank");
        a_inv_or_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].or_in_a_inv_en && !msk.mask_input_a |-> blank[k])
            else $error("inverted A did not blank");
        conj_route_a : assert property (@(posedge i_clock) disable iff (i_rst)
            (ctrl[k].conj_out_true_to_or && conj_out[k])
            || (ctrl[k].conj_out_inv_to_or && !conj_out[k]) |-> blank[k])
            else $error("AND output not routed");
        conj_sel_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k].conj_in_c_true_en && !msk.mask_input_c |-> !conj_out[k])
            else $error("AND gate ignored input C");
        pass_thru_a : assert property (@(posedge i_clock) disable iff (i_rst)
            i_clk_en && !blank[k] |=> o_cmp_event[k] == $past(cmp_f[k]))
            else $error("unblanked event altered");
        idle_gate_a : assert property (@(posedge i_clock) disable iff (i_rst)
            ctrl[k][13:6] == 8'h00 |-> !blank[k])
            else $error("blank with no OR input");
        // Bus side of each control word: store, read back, write-protect
        write_store_a : assert property (@(posedge i_clock) disable iff (i_rst)
            i_clk_en && access && i_apb.pwrite && (i_apb.paddr == 8'(4 * k))
            |=> ctrl[k] == ($past(i_apb.pwdata[15:0]) & `BM_CTRL_WMASK))
            else $error("control word not stored");
        read_back_a : assert property (@(posedge i_clock) disable iff (i_rst)
            access && !i_apb.pwrite && (i_apb.paddr == 8'(4 * k))
            |-> o_prdata == {16'h0000, ctrl[k]})
            else $error("control word read wrong");
        status_ro_a : assert property (@(posedge i_clock) disable iff (i_rst)
            i_clk_en && access && i_apb.pwrite && (i_apb.paddr == `BM_STATUS_OFF)
            |=> $stable(ctrl[k]))
            else $error("status write changed control");
        // Low enable must hold every flop, or a frozen block would drift
        ctrl_freeze_a : assert property (@(posedge i_clock) disable iff (i_rst)
            !i_clk_en |=> $stable(ctrl[k]) && $stable(o_blank[k]) && $stable(o_cmp_event[k]))
            else $error("state moved while frozen");
        blank_cov : cover property (@(posedge i_clock) disable iff (i_rst)
            i_clk_en && blank[k] ##1 i_clk_en && !blank[k]);
    end

    // An unmapped address must answer with an error
    slave_err_a : assert property (@(posedge i_clock) disable iff (i_rst)
        access && !mapped |-> o_pslverr)
        else $error("unmapped access not flagged");
    // A disagreeing pin sample must not move the filtered value
    glitch_hold_a : assert property (@(posedge i_clock) disable iff (i_rst)
        i_clk_en && (sync2 != sync3) |=> $stable(filt))
        else $error("glitch reached the gate");

    unimpl_zero_a : assert property (@(posedge i_clock) disable iff (i_rst)
        access && !i_apb.pwrite && (i_apb.paddr != `BM_STATUS_OFF) |-> !o_prdata[`BM_UNIMP_BIT])
        else $error("unimplemented bit read as one");
    write_cov : cover property (@(posedge i_clock) disable iff (i_rst)
        access && i_apb.pwrite && o_pready);
    err_cov : cover property (@(posedge i_clock) disable iff (i_rst)
        access && o_pslverr);
    pol_cov : cover property (@(posedge i_clock) disable iff (i_rst)
        ctrl[0].blank_polarity_select && o_blank[0]);
endmodule

/* sim/testbench.sv */
// Self-checking bench for the blanking mask gate
`timescale 1ns/100ps
`include "blank_mask_regs.svh"
module testbench;
    import blank_mask_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_clk_en = 1'b1;
    apb_req_t    i_apb = '0;
    mask_in_t    i_mask = '0;
    logic [2:0]  i_cmp_raw = 3'h0;
    logic        o_pready;
    logic        o_pslverr;
    logic [31:0] o_prdata;
    logic [2:0]  o_cmp_event;
    logic [2:0]  o_blank;
    logic [31:0] rd;
    logic        err;
    logic [15:0] w;
    logic [2:0]  pin;
    int          miscompares = 0;
    int          checks = 0;

    comparator_blanking_mask_gate uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_apb(i_apb),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
        .i_mask(i_mask), .i_cmp_raw(i_cmp_raw), .o_cmp_event(o_cmp_event),
        .o_blank(o_blank));

    // 20 MHz clock
    initial forever #25 i_clock = ~i_clock;

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // APB transfer; access held until pready, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_clock);
        i_apb.penable <= 1'b1;
        do begin
            @(posedge i_clock);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_apb <= '0;
    endtask

    // Pins need 4-5 enabled edges; 8 leaves margin
    task automatic settle;
        repeat (8) @(posedge i_clock);
    endtask

    initial begin
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        // Reset values of every word
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, 8'(r * 4), 32'h0);
            check("reset word", rd, 32'h0);
        end
        $display("Test reset done");
        // Writable bits hold, unimplemented bit reads zero
        apb(1'b1, `BM_CTRL1_OFF, 32'hFFFFFFFF);
        apb(1'b0, `BM_CTRL1_OFF, 32'h0);
        check("ctrl1 readback", rd, 32'h0000BFFF);
        apb(1'b1, `BM_CTRL1_OFF, 32'h0);
        apb(1'b1, `BM_STATUS_OFF, 32'hFFFFFFFF);
        apb(1'b0, `BM_CTRL2_OFF, 32'h0);
        check("status write ignored", rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", err, 32'h1);
        $display("Test register access done");
        // Each gate input alone; AND inputs reach OR via its true form
        for (int b = 0; b < 14; b++) begin
            if (b == 6 || b == 7) continue;
            w = (16'h1 << b) | ((b < 6) ? 16'h0040 : 16'h0000);
            apb(1'b1, `BM_CTRL0_OFF, {16'h0, w});
            pin = 3'(1 << ((b % 8) / 2));
            i_mask <= (b % 2) ? pin : ~pin;
            settle;
            check("blank on", o_blank[0], 32'h1);
            i_mask <= (b % 2) ? ~pin : pin;
            settle;
            check("blank off", o_blank[0], 32'h0);
        end
        // Inverted AND output blanks while the selected input is low
        apb(1'b1, `BM_CTRL0_OFF, 32'h000000A0);
        i_mask <= 3'b000;
        settle;
        check("inv and on", o_blank[0], 32'h1);
        i_mask <= 3'b100;
        settle;
        check("inv and off", o_blank[0], 32'h0);
        $display("Test gate inputs done");
        // Polarity: blanked output rests at the non-asserted level
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, `BM_CTRL0_OFF, {16'h0, p[0], 15'h2000});
            i_cmp_raw <= {3{~p[0]}};
            i_mask <= 3'b100;
            settle;
            check("blanked event", o_cmp_event[0], {31'h0, p[0]});
            i_mask <= 3'b000;
            settle;
            check("open event", o_cmp_event[0], {31'h0, ~p[0]});
        end
        $display("Test polarity done");
        // Clock enable low withholds the bus answer
        i_clk_en <= 1'b0;
        @(posedge i_clock);
        @(negedge i_clock);
        check("pready gated", o_pready, 32'h0);
        @(posedge i_clock);
        i_clk_en <= 1'b1;
        $display("Test clock enable done");
        // Comparators 1 and 2 gate on their own words; status shows live levels
        apb(1'b1, `BM_CTRL2_OFF, 32'h00000200);
        i_mask <= 3'b001;
        i_cmp_raw <= 3'b011;
        settle;
        check("blank per comparator", o_blank, 32'h4);
        check("event per comparator", o_cmp_event, 32'h3);
        apb(1'b0, `BM_STATUS_OFF, 32'h0);
        check("status word", rd, 32'h0000005C);
        $display("Test all comparators done");
        // Reset in mid-run clears control word 2 and the blank outputs
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        apb(1'b0, `BM_CTRL2_OFF, 32'h0);
        check("ctrl2 after reset", rd, 32'h0);
        check("blank after reset", o_blank, 32'h0);
        $display("Test mid-run reset done");
        print_verdict;
    end

    // Watchdog well past the expected run of about 350 cycles
    initial begin
        repeat (3000) @(posedge i_clock);
        miscompares++;
        print_verdict;
    end
endmodule
